// ---- hdl/ttu_cfg.svh ----
// Register offsets, field positions and reset values of the trigger unit control block
`ifndef TTU_CFG_SVH
`define TTU_CFG_SVH

`define TTU_NUM_UNITS      3
`define TTU_ADDR_W         16
`define TTU_UIDX_ADDR      16'h0500
`define TTU_CSR_ADDR       16'h0504
`define TTU_IRQ_STAT_ADDR  16'h0508
`define TTU_IRQ_MASK_ADDR  16'h050C
`define TTU_CTL1_ADDR      16'h0538

`define TTU_CHAIN_ON_BIT   31
`define TTU_CHAIN_LAST_BIT 30
`define TTU_UP_SEL_HI      27
`define TTU_UP_SEL_LO      26
`define TTU_FIRE_NOW_BIT   25
`define TTU_REPORT_BIT     24
`define TTU_EDGE_BIT       23
`define TTU_CTL1_WMASK     32'hCF80_0000
`define TTU_CTL1_RESET     32'h0000_0000

`define TTU_ACTIVE_BIT     4
`define TTU_ARM_BIT        3
`define TTU_SOFT_CLR_BIT   2
`define TTU_DONE_LSB       0
`define TTU_FAULT_LSB      4

`endif

// ---- hdl/ttu_pkg.sv ----
// Types shared by the trigger unit control block
package ttu_pkg;
	typedef enum logic [1:0] {
		TTU_IDLE,
		TTU_WAIT,
		TTU_FIRE
	} ttu_state_e;
endpackage

// ---- hdl/ttu_ctrl.sv ----
// Control of three chainable time-triggered output units with register port and interrupt
`timescale 1ns/1ns
`include "ttu_cfg.svh"

// Overview of operation
// R01 - Chain bit set makes unit a cascade member
// R02 - Last-marker bit marks final unit of chain
// R03 - No last marker: chain cycles without end
// R04 - Software soft-clears unit to halt endless loop
// R05 - Two-bit field selects upstream done unit
// R06 - Fire-now fires at once if target passed
// R07 - Report bit enables done/fault flags and interrupt
// R08 - Edge bit takes output from falling-edge copy of done, one cycle later
// R09 - Index pointer bits 1:0 select unit copy
// R10 - Arm bit self-clears on fire; arm head only
// R11 - Non-head unit starts on upstream done
module ttu_ctrl (
	input  wire logic                      clk_i,
	input  wire logic                      rstn_i,
	input  wire logic [`TTU_ADDR_W-1:0]    addr_i,
	input  wire logic [31:0]               wdata_i,
	input  wire logic                      wr_i,
	input  wire logic                      rd_i,
	output logic      [31:0]               rdata_o,
	input  wire logic [`TTU_NUM_UNITS-1:0] target_reached_i,
	input  wire logic [`TTU_NUM_UNITS-1:0] target_past_i,
	output logic      [`TTU_NUM_UNITS-1:0] trig_o,
	output logic      [`TTU_NUM_UNITS-1:0] done_o,
	output logic                           irq_o
);
	localparam int NU = `TTU_NUM_UNITS;

	ttu_pkg::ttu_state_e state_r [NU];
	ttu_pkg::ttu_state_e state_nxt [NU];
	logic [31:0]   ctl1_r [NU];
	logic [31:0]   ctl1_nxt [NU];
	logic [NU-1:0] arm_r;
	logic [NU-1:0] arm_nxt;
	logic [NU-1:0] done_r;
	logic [NU-1:0] done_nxt;
	logic [NU-1:0] fire_ev;
	logic [NU-1:0] fault_ev;
	logic [1:0]    uidx_r;
	logic [1:0]    uidx_nxt;
	logic [NU-1:0] dstat_r;
	logic [NU-1:0] dstat_nxt;
	logic [NU-1:0] fstat_r;
	logic [NU-1:0] fstat_nxt;
	logic [NU-1:0] dmask_r;
	logic [NU-1:0] dmask_nxt;
	logic [NU-1:0] fmask_r;
	logic [NU-1:0] fmask_nxt;
	logic [31:0]   rdata_nxt;
	logic          irq_nxt;
	logic [NU-1:0] pos_r;
	logic [NU-1:0] pos_nxt;
	logic [NU-1:0] neg_r;
	logic [NU-1:0] trig_nxt;

	// Done of the selected upstream unit; a last unit passes no done on
	function automatic logic up_done(input logic [1:0] sel, input logic [NU-1:0] dn, input logic [NU-1:0] last);
		logic r;
		r = 1'b0;
		case (sel)
			2'h1: r = dn[0] & ~last[0];
			2'h2: r = dn[1] & ~last[1];
			2'h3: r = dn[2] & ~last[2];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	function automatic logic sel_ok(input logic [1:0] idx);
		return idx < 2'(NU);
	endfunction

	logic [NU-1:0] last_v;
	always_comb begin
		for (int u = 0; u < NU; u++) begin
			last_v[u] = ctl1_r[u][`TTU_CHAIN_LAST_BIT]; // R02
		end
	end

	wire wr_uidx  = wr_i && addr_i == `TTU_UIDX_ADDR;
	wire wr_csr   = wr_i && addr_i == `TTU_CSR_ADDR && sel_ok(uidx_r); // R09
	wire wr_stat  = wr_i && addr_i == `TTU_IRQ_STAT_ADDR;
	wire wr_mask  = wr_i && addr_i == `TTU_IRQ_MASK_ADDR;
	wire wr_ctl1  = wr_i && addr_i == `TTU_CTL1_ADDR && sel_ok(uidx_r); // R09

	// Unit sequencing
	always_comb begin
		uidx_nxt = wr_uidx ? wdata_i[1:0] : uidx_r; // R09
		for (int u = 0; u < NU; u++) begin
			logic cur;
			logic clr;
			logic start;
			cur = wr_csr && uidx_r == 2'(u);
			clr = cur && wdata_i[`TTU_SOFT_CLR_BIT];
			start = ctl1_r[u][`TTU_CHAIN_ON_BIT] &&
				up_done(ctl1_r[u][`TTU_UP_SEL_HI:`TTU_UP_SEL_LO], done_r, last_v); // R01 R03 R05 R11
			state_nxt[u] = state_r[u];
			ctl1_nxt[u]  = ctl1_r[u];
			arm_nxt[u]   = arm_r[u];
			done_nxt[u]  = 1'b0;
			fire_ev[u]   = 1'b0;
			fault_ev[u]  = 1'b0;
			if (wr_ctl1 && uidx_r == 2'(u)) begin
				ctl1_nxt[u] = wdata_i & `TTU_CTL1_WMASK;
			end
			if (cur && wdata_i[`TTU_ARM_BIT]) begin
				arm_nxt[u] = 1'b1;
			end
			case (state_r[u])
				ttu_pkg::TTU_IDLE: begin
					if (start) begin
						state_nxt[u] = ttu_pkg::TTU_FIRE; // R11
					end else if (arm_r[u]) begin
						state_nxt[u] = ttu_pkg::TTU_WAIT;
					end
				end
				ttu_pkg::TTU_WAIT: begin
					if (start || target_reached_i[u]) begin
						state_nxt[u] = ttu_pkg::TTU_FIRE;
					end else if (target_past_i[u]) begin
						if (ctl1_r[u][`TTU_FIRE_NOW_BIT]) begin
							state_nxt[u] = ttu_pkg::TTU_FIRE; // R06
						end else begin
							state_nxt[u] = ttu_pkg::TTU_IDLE; // R06
							arm_nxt[u]   = 1'b0;
							fault_ev[u]  = 1'b1;
						end
					end
				end
				ttu_pkg::TTU_FIRE: begin
					state_nxt[u] = ttu_pkg::TTU_IDLE;
					arm_nxt[u]   = 1'b0; // R10
					done_nxt[u]  = 1'b1;
					fire_ev[u]   = 1'b1;
				end
				default: state_nxt[u] = ttu_pkg::TTU_IDLE;
			endcase
			if (clr) begin
				state_nxt[u] = ttu_pkg::TTU_IDLE; // R04
				arm_nxt[u]   = 1'b0;
				done_nxt[u]  = 1'b0;
				ctl1_nxt[u]  = `TTU_CTL1_RESET;
				fire_ev[u]   = 1'b0;
				fault_ev[u]  = 1'b0;
			end
			pos_nxt[u]  = state_nxt[u] == ttu_pkg::TTU_FIRE;
			trig_nxt[u] = ctl1_r[u][`TTU_EDGE_BIT] ? neg_r[u] : pos_r[u]; // R08
		end
	end

	// Interrupt status, mask and read port
	always_comb begin
		logic [NU-1:0] rep;
		rep = '0;
		for (int u = 0; u < NU; u++) begin
			rep[u] = ctl1_r[u][`TTU_REPORT_BIT];
		end
		dstat_nxt = (wr_stat ? dstat_r & ~wdata_i[`TTU_DONE_LSB +: NU] : dstat_r) | (fire_ev & rep);   // R07
		fstat_nxt = (wr_stat ? fstat_r & ~wdata_i[`TTU_FAULT_LSB +: NU] : fstat_r) | (fault_ev & rep); // R07
		dmask_nxt = wr_mask ? wdata_i[`TTU_DONE_LSB +: NU] : dmask_r;
		fmask_nxt = wr_mask ? wdata_i[`TTU_FAULT_LSB +: NU] : fmask_r;
		irq_nxt   = |{dstat_nxt & dmask_nxt, fstat_nxt & fmask_nxt};
		rdata_nxt = 32'h0000_0000;
		if (rd_i) begin
			case (addr_i)
				`TTU_UIDX_ADDR: rdata_nxt[1:0] = uidx_r;
				`TTU_CSR_ADDR: if (sel_ok(uidx_r)) begin
					rdata_nxt[`TTU_ACTIVE_BIT] = state_r[uidx_r] != ttu_pkg::TTU_IDLE;
					rdata_nxt[`TTU_ARM_BIT]    = arm_r[uidx_r];
				end
				`TTU_IRQ_STAT_ADDR: begin
					rdata_nxt[`TTU_DONE_LSB +: NU]  = dstat_r;
					rdata_nxt[`TTU_FAULT_LSB +: NU] = fstat_r;
				end
				`TTU_IRQ_MASK_ADDR: begin
					rdata_nxt[`TTU_DONE_LSB +: NU]  = dmask_r;
					rdata_nxt[`TTU_FAULT_LSB +: NU] = fmask_r;
				end
				`TTU_CTL1_ADDR: if (sel_ok(uidx_r)) begin
					rdata_nxt = ctl1_r[uidx_r]; // R09
				end
				default: rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			for (int u = 0; u < NU; u++) begin
				state_r[u] <= ttu_pkg::TTU_IDLE;
				ctl1_r[u]  <= `TTU_CTL1_RESET;
			end
			arm_r   <= '0;
			done_r  <= '0;
			pos_r   <= '0;
			trig_o  <= '0;
			done_o  <= '0;
			uidx_r  <= 2'h0;
			dstat_r <= '0;
			fstat_r <= '0;
			dmask_r <= '0;
			fmask_r <= '0;
			rdata_o <= 32'h0000_0000;
			irq_o   <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ctl1_r  <= ctl1_nxt;
			arm_r   <= arm_nxt;
			done_r  <= done_nxt;
			pos_r   <= pos_nxt;
			trig_o  <= trig_nxt;
			done_o  <= done_nxt;
			uidx_r  <= uidx_nxt;
			dstat_r <= dstat_nxt;
			fstat_r <= fstat_nxt;
			dmask_r <= dmask_nxt;
			fmask_r <= fmask_nxt;
			rdata_o <= rdata_nxt;
			irq_o   <= irq_nxt;
		end
	end

	// Falling-edge copy of done, half a cycle after the rising launch; it reaches trig_o at the next rising edge, one cycle after done
	always_ff @(negedge clk_i) begin
		if (!rstn_i) begin
			neg_r <= '0;
		end else begin
			neg_r <= done_r; // R08
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	sequence fire_seq(int u);
		state_r[u] == ttu_pkg::TTU_FIRE ##1 done_r[u];
	endsequence

	chain_start_a: assert property (done_r[0] && !last_v[0] && ctl1_r[1][`TTU_CHAIN_ON_BIT] &&
		ctl1_r[1][`TTU_UP_SEL_HI:`TTU_UP_SEL_LO] == 2'h1 && !wr_csr |=> state_r[1] == ttu_pkg::TTU_FIRE) // R11
		else $error("downstream unit did not start on upstream done");
	solo_nostart_a: assert property (done_r[0] && !ctl1_r[1][`TTU_CHAIN_ON_BIT] && state_r[1] == ttu_pkg::TTU_IDLE &&
		!arm_r[1] |=> state_r[1] != ttu_pkg::TTU_FIRE) // R01
		else $error("standalone unit followed upstream done");
	tail_stop_a: assert property (done_r[1] && last_v[1] && ctl1_r[0][`TTU_UP_SEL_HI:`TTU_UP_SEL_LO] == 2'h2 &&
		state_r[0] == ttu_pkg::TTU_IDLE && !arm_r[0] |=> state_r[0] != ttu_pkg::TTU_FIRE) // R02
		else $error("chain continued past last unit");
	fire_now_a: assert property (state_r[0] == ttu_pkg::TTU_WAIT && target_past_i[0] &&
		ctl1_r[0][`TTU_FIRE_NOW_BIT] && !wr_csr |=> fire_seq(0)) // R06
		else $error("fire-now did not fire");
	miss_fault_a: assert property (state_r[0] == ttu_pkg::TTU_WAIT && target_past_i[0] && !target_reached_i[0] &&
		!ctl1_r[0][`TTU_FIRE_NOW_BIT] && ctl1_r[0][`TTU_REPORT_BIT] && !wr_csr |=> fstat_r[0]) // R06 R07
		else $error("missed target not reported as fault");
	report_gate_a: assert property (state_r[0] == ttu_pkg::TTU_FIRE && !ctl1_r[0][`TTU_REPORT_BIT] &&
		!dstat_r[0] |=> !dstat_r[0]) // R07
		else $error("done flag set with reporting off");
	edge_fall_a: assert property (ctl1_r[2][`TTU_EDGE_BIT] && $stable(ctl1_r[2][`TTU_EDGE_BIT]) && done_r[2] |->
		!trig_o[2] ##1 trig_o[2]) // R08
		else $error("falling-edge output not selected");
	arm_clear_a: assert property (state_r[1] == ttu_pkg::TTU_FIRE && !wr_csr |=> !arm_r[1] && done_o[1]) // R10
		else $error("arm not cleared after firing");
	soft_clear_a: assert property (wr_csr && uidx_r == 2'h1 && wdata_i[`TTU_SOFT_CLR_BIT] |=>
		(state_r[1] == ttu_pkg::TTU_IDLE && ctl1_r[1] == `TTU_CTL1_RESET) [*2]) // R04 R03
		else $error("soft clear did not halt unit");
	index_read_a: assert property (rd_i && addr_i == `TTU_CTL1_ADDR && uidx_r == 2'h3 |=> rdata_o == 32'h0000_0000) // R09
		else $error("unmapped unit index returned data");
	irq_level_a: assert property (irq_o == |{dstat_r & dmask_r, fstat_r & fmask_r}) // R07
		else $error("interrupt output disagrees with status and mask");
endmodule // ttu_ctrl

// ---- verification/tb.sv ----
// Self-checking testbench for the trigger unit control block
`timescale 1ns/1ns
`include "ttu_cfg.svh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
	$display("BAD %s exp %h got %h", nm, exp, got); end end

module tb;
	logic        clk_i = 0;
	logic        rstn_i = 0;
	logic [15:0] addr_i = 16'h0000;
	logic [31:0] wdata_i = 32'h0000_0000;
	logic        wr_i = 0;
	logic        rd_i = 0;
	logic [2:0]  target_reached_i = 3'h7;
	logic [2:0]  target_past_i = 3'h0;
	logic [31:0] rdata_o;
	logic [2:0]  trig_o;
	logic [2:0]  done_o;
	logic        irq_o;
	int          n_fail = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          n;
	logic [31:0] d;
	logic [2:0]  seen;
	logic [79:0] rows [9];

	ttu_ctrl u_ttu_ctrl (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .target_reached_i(target_reached_i), .target_past_i(target_past_i),
		.trig_o(trig_o), .done_o(done_o), .irq_o(irq_o));

	always #10 clk_i = ~clk_i;

	// Cut a hang short
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 4000) begin
			n_fail++;
			$display("BAD timeout");
			print_verdict();
		end
	end

	task wr(input logic [15:0] a, input logic [31:0] v);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task rd(input logic [15:0] a, output logic [31:0] v);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask

	// Waits for a trigger or done pulse; k reaches 12 when none came
	task wait_bit(input int u, input bit dn, output int k);
		k = 0;
		#1;
		while (((dn ? done_o[u] : trig_o[u]) !== 1'b1) && k < 12) begin
			@(posedge clk_i);
			#1 k++;
		end
	endtask

	task fire(input logic [1:0] u, input logic [31:0] ctl, input bit dn, output int k);
		wr(`TTU_UIDX_ADDR, {30'h0, u});
		wr(`TTU_CTL1_ADDR, ctl);
		wr(`TTU_CSR_ADDR, 32'h0000_0008);
		wait_bit(u, dn, k);
	endtask

	task print_verdict;
		$display("tests %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		rows[0] = {`TTU_UIDX_ADDR, 32'h0000_0001, 32'h0000_0001};
		rows[1] = {`TTU_CTL1_ADDR, 32'h8100_0000, 32'h8100_0000};
		rows[2] = {`TTU_UIDX_ADDR, 32'h0000_0000, 32'h0000_0000};
		rows[3] = {`TTU_CTL1_ADDR, 32'hFFFF_FFFF, 32'hCF80_0000};
		rows[4] = {`TTU_CTL1_ADDR, 32'h0000_0000, 32'h0000_0000};
		rows[5] = {`TTU_UIDX_ADDR, 32'h0000_0003, 32'h0000_0003};
		rows[6] = {`TTU_CTL1_ADDR, 32'hFFFF_FFFF, 32'h0000_0000};
		rows[7] = {16'h0600, 32'hFFFF_FFFF, 32'h0000_0000};
		rows[8] = {`TTU_IRQ_MASK_ADDR, 32'h0000_0077, 32'h0000_0077};
		repeat (6) @(posedge clk_i);
		rstn_i <= 1'b1;
		#1 `CHK("trig_rst", 3'h0, trig_o)
		`CHK("irq_rst", 1'b0, irq_o)
		rd(`TTU_CTL1_ADDR, d);
		`CHK("ctl1_rst", 32'h0000_0000, d)
		$display("end reset");
		for (int i = 0; i < 9; i++) begin
			wr(rows[i][79:64], rows[i][63:32]);
			rd(rows[i][79:64], d);
			`CHK("row", rows[i][31:0], d)
		end
		$display("end table");
		fire(0, 32'h0100_0000, 0, n);
		`CHK("trig0", 1'b1, trig_o[0])
		`CHK("done0", 1'b1, done_o[0])
		`CHK("irq_on", 1'b1, irq_o)
		@(posedge clk_i);
		#1 `CHK("trig0_len", 1'b0, trig_o[0])
		rd(`TTU_CSR_ADDR, d);
		`CHK("arm_clr", 32'h0000_0000, d)
		rd(`TTU_IRQ_STAT_ADDR, d);
		`CHK("stat", 32'h0000_0001, d)
		wr(`TTU_IRQ_STAT_ADDR, 32'h0000_0001);
		rd(`TTU_IRQ_STAT_ADDR, d);
		`CHK("stat_w1c", 32'h0000_0000, d)
		`CHK("irq_off", 1'b0, irq_o)
		wr(`TTU_IRQ_MASK_ADDR, 32'h0000_0000);
		fire(0, 32'h0100_0000, 0, n);
		`CHK("irq_mask", 1'b0, irq_o)
		wr(`TTU_IRQ_STAT_ADDR, 32'h0000_0001);
		fire(0, 32'h0000_0000, 0, n);
		rd(`TTU_IRQ_STAT_ADDR, d);
		`CHK("no_report", 32'h0000_0000, d)
		$display("end report");
		@(posedge clk_i);
		target_reached_i <= 3'h0;
		target_past_i <= 3'h7;
		fire(0, 32'h0100_0000, 0, n);
		`CHK("fault_nofire", 12, n)
		rd(`TTU_IRQ_STAT_ADDR, d);
		`CHK("fault", 32'h0000_0010, d)
		wr(`TTU_IRQ_STAT_ADDR, 32'h0000_0010);
		fire(0, 32'h0300_0000, 0, n);
		`CHK("fire_now", 1'b1, trig_o[0])
		@(posedge clk_i);
		target_reached_i <= 3'h7;
		target_past_i <= 3'h0;
		$display("end fire_now");
		wr(`TTU_UIDX_ADDR, 32'h0000_0001);
		wr(`TTU_CTL1_ADDR, 32'hC400_0000);
		fire(0, 32'h8900_0000, 0, n);
		`CHK("head", 1'b1, trig_o[0])
		@(posedge clk_i);
		#1 `CHK("next_early", 1'b0, trig_o[1])
		@(posedge clk_i);
		#1 `CHK("next", 1'b1, trig_o[1])
		wait_bit(0, 0, n);
		`CHK("tail_stop", 12, n)
		wr(`TTU_UIDX_ADDR, 32'h0000_0001);
		wr(`TTU_CTL1_ADDR, 32'h8400_0000);
		fire(0, 32'h8900_0000, 0, n);
		@(posedge clk_i);
		wait_bit(0, 0, n);
		`CHK("loop", 1'b1, trig_o[0])
		wr(`TTU_CSR_ADDR, 32'h0000_0004);
		wr(`TTU_UIDX_ADDR, 32'h0000_0001);
		wr(`TTU_CSR_ADDR, 32'h0000_0004);
		seen = 3'h0;
		repeat (12) begin
			@(posedge clk_i);
			#1 seen = seen | trig_o;
		end
		`CHK("halted", 3'h0, seen)
		rd(`TTU_CTL1_ADDR, d);
		`CHK("soft_ctl1", 32'h0000_0000, d)
		$display("end chain");
		fire(2, 32'h0080_0000, 1, n);
		`CHK("neg_early", 1'b0, trig_o[2])
		@(posedge clk_i);
		#1 `CHK("neg_late", 1'b1, trig_o[2])
		$display("end edge");
		print_verdict();
	end
endmodule // tb
